// ### async_serial_uart_core.sv
// full-duplex serial transceiver with shared data register and status flags
// assumes a single-cycle processor data-memory port on mclk; rx_pin is async
`timescale 1ns/1ps
// Functional notes
// R1: characters carry eight or nine data bits, ninth bit kept apart.
// R2: parity is even, odd or absent by configuration.
// R3: one or two stop bits by configuration.
// R4: bit timing comes from an 8-bit programmable baud divisor.
// R5: received characters queue in a two-entry buffer.
// R6: address detect interrupts only on characters whose last bit is one.
// R7: interrupts for tx empty, tx idle, rx full, overrun, address detect.
// R8: enabled pins act as serial pins with pull-ups switched off.
// R9: clearing any enable floats the matching pin.
// R10: written byte moves to shift register, sent LSB first.
// R11: received bits shift in LSB first, then move to the buffer.
// R12: one data address: write feeds transmit, read returns receive data.
// R13: status bit 7 parity error, cleared by status read then data access.
// R14: status bit 6 noise, set with rx available, never on overrun.
// R15: status bit 5 framing error, cleared by status read then data access.
// R16: status bit 4 overrun blocks transfers until status read then data access.
// R17: status bit 3 low from start detection until stop completes.
// R18: status bit 2 sets when data enters the buffer; irq if enabled.
// R19: receive errors flag in the same cycle as rx available.
// R20: rx available clears after status read, data read, buffer empty.
// R21: status bit 1 high when nothing queued or sending; line high.
// R22: tx idle clears after status read then data write.
// R23: status bit 0 sets on transfer to shift register; same clear sequence.
// R24: parity select zero means even, one means odd.
// R25: ninth tx bit from write-only control bit, rx ninth read-only.
// R26: break holds the line low at least thirteen bits and until cleared.
// R27: low start bit, high stop bits, line high between frames.
// R28: each bit sampled three times; disagreement reports noise; the core drops a disagreement in the final stop bit.
module async_serial_uart_core (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            tx_pin_oe_n,
  output logic            tx_pullup_off,
  output logic            rx_pullup_off,
  output logic            irq
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ctl1_reg, ctl2_reg, baud_reg, seen_reg;
  logic       rx_s1_reg, rx_s2_reg, tick;
  logic       parity_error_flag_reg, noise_reg, framing_error_flag_reg, ovr_reg, rxav_reg, txdn_reg, txem_reg;
  logic       adr_hit_reg;
  uart_pkg::rx_state_t rx_state_reg, rx_state_next;
  uart_pkg::tx_state_t tx_state_reg, tx_state_next;
  // buffer and status nets shared by the control, buffer and flag logic
  logic [8:0] rx_char;
  logic [8:0] fifo_mem [2];
  logic [1:0] fifo_cnt_reg, cnt_after;
  logic       rd_ptr_reg, wr_ptr_reg, rx_fe_reg, push, pop;
  logic [7:0] status;

  // register port decode
  wire acc_data = (reg_addr == uart_pkg::A_DATA);
  wire rd_data  = reg_rd && acc_data;
  wire wr_data  = reg_wr && acc_data;
  wire any_data = rd_data || wr_data;
  wire rd_stat  = reg_rd && (reg_addr == uart_pkg::A_STAT);
  wire wr_ctl1  = reg_wr && (reg_addr == uart_pkg::A_CTL1);
  wire wr_ctl2  = reg_wr && (reg_addr == uart_pkg::A_CTL2);
  wire wr_baud  = reg_wr && (reg_addr == uart_pkg::A_BAUD);
  wire g_on     = ctl1_reg[uart_pkg::C1_ON];
  wire nine     = ctl1_reg[uart_pkg::C1_NINE];
  wire par_en   = ctl1_reg[uart_pkg::C1_PEN];
  wire par_odd  = ctl1_reg[uart_pkg::C1_ODD];
  wire brk_req  = ctl1_reg[uart_pkg::C1_BRK];
  wire tx_act   = g_on && ctl2_reg[uart_pkg::C2_TXON];
  wire rx_act   = g_on && ctl2_reg[uart_pkg::C2_RXON];

  // even parity bit of a character, inverted for odd
  function automatic logic par_of(input logic [8:0] d, input logic n9, input logic odd);
    par_of = (^d[7:0]) ^ (n9 & d[8]) ^ odd; // R24
  endfunction : par_of

  // majority of three samples from a two-bit ones count
  function automatic logic maj(input logic [1:0] ones);
    maj = (ones >= 2'h2);
  endfunction : maj

  ////////////////////////////////////////////////////////////////////////
  // control registers; clearing the global enable drops the enables and break
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl1_reg <= uart_pkg::CTL_RST;
      ctl2_reg <= uart_pkg::CTL_RST;
      baud_reg <= uart_pkg::BAUD_RST;
    end else begin
      if (wr_ctl1) ctl1_reg <= {reg_wdata[7:2], ctl1_reg[uart_pkg::C1_RX8], reg_wdata[0]};
      if (wr_ctl2) ctl2_reg <= reg_wdata;
      if (wr_baud) baud_reg <= reg_wdata; // R4
      if (!g_on) begin
        ctl1_reg[uart_pkg::C1_BRK]  <= 1'b0;
        ctl2_reg[uart_pkg::C2_TXON] <= 1'b0;
        ctl2_reg[uart_pkg::C2_RXON] <= 1'b0;
      end
      // ninth bit follows whichever entry is at the head after this edge
      if (pop && fifo_cnt_reg == 2'h2) ctl1_reg[uart_pkg::C1_RX8] <= fifo_mem[~rd_ptr_reg][8]; // R25
      else if (push && cnt_after == 2'h1) ctl1_reg[uart_pkg::C1_RX8] <= rx_char[8];
    end
  end

  baud_tick_gen #(.DIV_W(8)) u_baud (
    .mclk    (mclk),
    .resetn  (resetn),
    .clear   (!g_on),
    .divisor (baud_reg),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive line synchroniser; only the second stage is looked at
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  logic [3:0] rx_tk_reg, rx_bit_reg;
  logic [1:0] rx_ones_reg;
  logic [8:0] rx_sh_reg;
  logic       rx_nz_reg, rx_pe_reg;
  wire        rx_end  = tick && (rx_tk_reg == uart_pkg::OVS_LAST);
  wire        rx_smp  = tick && rx_tk_reg >= uart_pkg::SMP_FIRST && rx_tk_reg <= uart_pkg::SMP_LAST;
  wire        rx_bitv = maj(rx_ones_reg);
  wire        rx_disagree = (rx_ones_reg != 2'h0) && (rx_ones_reg != 2'h3); // R28
  wire [3:0]  n_last  = nine ? 4'h8 : 4'h7;
  wire        two_stp = ctl1_reg[uart_pkg::C1_STP2];
  wire        rx_done = rx_end && (rx_state_reg == uart_pkg::RX_STOP) && !(two_stp && rx_bit_reg == 4'h0);
  // the shifted word sits high in the register; align it for 8-bit frames
  assign rx_char = nine ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};

  // receive sequencer, three samples per bit around the middle
  always_comb begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      uart_pkg::RX_IDLE:  if (tick && !rx_s2_reg) rx_state_next = uart_pkg::RX_START; // R27
      uart_pkg::RX_START: if (tick && rx_tk_reg == uart_pkg::START_MID && rx_s2_reg)
                            rx_state_next = uart_pkg::RX_IDLE;
                          else if (rx_end) rx_state_next = uart_pkg::RX_DATA;
      uart_pkg::RX_DATA:  if (rx_end && rx_bit_reg == n_last)
                            rx_state_next = par_en ? uart_pkg::RX_PAR : uart_pkg::RX_STOP; // R1 R2
      uart_pkg::RX_PAR:   if (rx_end) rx_state_next = uart_pkg::RX_STOP;
      uart_pkg::RX_STOP:  if (rx_done) rx_state_next = uart_pkg::RX_IDLE; // R3
      default:            rx_state_next = uart_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
      rx_tk_reg    <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_ones_reg  <= 2'h0;
      rx_sh_reg    <= 9'h000;
      rx_nz_reg    <= 1'b0;
      rx_pe_reg    <= 1'b0;
    end else if (!rx_act) begin
      rx_state_reg <= uart_pkg::RX_IDLE;
      rx_tk_reg    <= 4'h0;
    end else begin
      rx_state_reg <= rx_state_next;
      if (rx_state_reg == uart_pkg::RX_IDLE) begin
        rx_tk_reg  <= 4'h0;
        rx_bit_reg <= 4'h0;
        rx_nz_reg  <= 1'b0;
        rx_pe_reg  <= 1'b0;
        rx_ones_reg <= 2'h0;
      end else if (tick) begin
        rx_tk_reg <= rx_tk_reg + 4'h1;
        if (rx_end) begin
          rx_ones_reg <= 2'h0;
          rx_nz_reg   <= rx_nz_reg | rx_disagree;
          rx_bit_reg  <= (rx_state_next != rx_state_reg) ? 4'h0 : rx_bit_reg + 4'h1;
        end else if (rx_smp) rx_ones_reg <= rx_ones_reg + {1'b0, rx_s2_reg};
        if (rx_end && rx_state_reg == uart_pkg::RX_DATA) rx_sh_reg <= {rx_bitv, rx_sh_reg[8:1]}; // R11
        if (rx_end && rx_state_reg == uart_pkg::RX_PAR)
          rx_pe_reg <= (rx_bitv != par_of(rx_char, nine, par_odd)); // R13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry receive buffer; overrun stops all pushes until cleared
  wire        ovf  = rx_done && !ovr_reg && fifo_cnt_reg == 2'h2;
  assign push      = rx_done && !ovr_reg && fifo_cnt_reg != 2'h2; // R5 R16
  assign pop       = rd_data && fifo_cnt_reg != 2'h0;
  assign cnt_after = fifo_cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fifo_cnt_reg <= 2'h0;
      rd_ptr_reg   <= 1'b0;
      wr_ptr_reg   <= 1'b0;
      rx_fe_reg    <= 1'b0;
    end else if (!rx_act) begin
      fifo_cnt_reg <= 2'h0;
      rd_ptr_reg   <= 1'b0;
      wr_ptr_reg   <= 1'b0;
    end else begin
      fifo_cnt_reg <= cnt_after;
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)  rd_ptr_reg <= ~rd_ptr_reg;
      if (rx_end && rx_state_reg == uart_pkg::RX_STOP) rx_fe_reg <= !rx_bitv; // first of two stops kept
    end
  end

  always_ff @(posedge mclk) begin
    if (push) fifo_mem[wr_ptr_reg] <= rx_char;
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over the software clear sequence
  wire clr_err  = any_data;
  wire stop_bad = rx_done && (!rx_bitv || rx_fe_reg && two_stp);
  wire last_one = nine ? rx_char[8] : rx_char[7];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      seen_reg    <= 8'h00;
      parity_error_flag_reg    <= 1'b0;
      noise_reg   <= 1'b0;
      framing_error_flag_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
      rxav_reg    <= 1'b0;
      adr_hit_reg <= 1'b0;
    end else if (!g_on) begin
      seen_reg    <= 8'h00;
      parity_error_flag_reg    <= 1'b0;
      noise_reg   <= 1'b0;
      framing_error_flag_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
      rxav_reg    <= 1'b0;
      adr_hit_reg <= 1'b0;
    end else begin
      if (rd_stat) seen_reg <= status;
      else if (any_data) seen_reg <= 8'h00;
      if (push && par_en && rx_pe_reg) parity_error_flag_reg <= 1'b1; // R13 R19
      else if (clr_err && seen_reg[uart_pkg::S_PARITY_ERROR_FLAG]) parity_error_flag_reg <= 1'b0;
      if (push && rx_nz_reg) noise_reg <= 1'b1; // R14 R19
      else if (clr_err && seen_reg[uart_pkg::S_NOISE]) noise_reg <= 1'b0;
      if (push && stop_bad) framing_error_flag_reg <= 1'b1; // R15 R19
      else if (clr_err && seen_reg[uart_pkg::S_FRAMING_ERROR_FLAG]) framing_error_flag_reg <= 1'b0;
      if (ovf) ovr_reg <= 1'b1; // R16
      else if (clr_err && seen_reg[uart_pkg::S_OVR]) ovr_reg <= 1'b0;
      if (push) rxav_reg <= 1'b1; // R18
      else if (rd_data && seen_reg[uart_pkg::S_RXAV] && cnt_after == 2'h0) rxav_reg <= 1'b0; // R20
      if (push && ctl2_reg[uart_pkg::C2_ADR] && last_one) adr_hit_reg <= 1'b1; // R6
      else if (cnt_after == 2'h0) adr_hit_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter: holding register, hidden shift register, break generator
  logic [8:0] hold_reg, tx_sh_reg;
  logic       hold_vld_reg, tx_par_reg;
  logic [3:0] tx_tk_reg, tx_bit_reg;
  wire        tx_end  = tick && (tx_tk_reg == uart_pkg::OVS_LAST);
  wire        tx_load = (tx_state_reg == uart_pkg::TX_IDLE) && hold_vld_reg && tick;
  wire        brk_ok  = tx_bit_reg >= uart_pkg::BRK_BITS;

  always_comb begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      uart_pkg::TX_IDLE:  if (tx_load) tx_state_next = uart_pkg::TX_START; // R10
                          else if (tick && brk_req) tx_state_next = uart_pkg::TX_BRK; // R26
      uart_pkg::TX_START: if (tx_end) tx_state_next = uart_pkg::TX_DATA;
      uart_pkg::TX_DATA:  if (tx_end && tx_bit_reg == n_last)
                            tx_state_next = par_en ? uart_pkg::TX_PAR : uart_pkg::TX_STOP; // R1 R2
      uart_pkg::TX_PAR:   if (tx_end) tx_state_next = uart_pkg::TX_STOP;
      uart_pkg::TX_STOP:  if (tx_end && !(two_stp && tx_bit_reg == 4'h0))
                            tx_state_next = uart_pkg::TX_IDLE; // R3
      uart_pkg::TX_BRK:   if (tx_end && brk_ok && !brk_req) tx_state_next = uart_pkg::TX_IDLE; // R26
      default:            tx_state_next = uart_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= uart_pkg::TX_IDLE;
      hold_reg     <= 9'h000;
      hold_vld_reg <= 1'b0;
      tx_sh_reg    <= 9'h000;
      tx_par_reg   <= 1'b0;
      tx_tk_reg    <= 4'h0;
      tx_bit_reg   <= 4'h0;
    end else if (!tx_act) begin
      tx_state_reg <= uart_pkg::TX_IDLE; // aborts frame and flushes holding
      hold_vld_reg <= 1'b0;
      tx_tk_reg    <= 4'h0;
    end else begin
      tx_state_reg <= tx_state_next;
      if (wr_data) begin
        hold_reg     <= {ctl1_reg[uart_pkg::C1_TX8], reg_wdata}; // R12 R25
        hold_vld_reg <= 1'b1;
      end else if (tx_load) hold_vld_reg <= 1'b0;
      if (tx_load) begin
        tx_sh_reg  <= hold_reg;
        tx_par_reg <= par_of(hold_reg, nine, par_odd); // R2
      end else if (tx_end && tx_state_reg == uart_pkg::TX_DATA) tx_sh_reg <= tx_sh_reg >> 1; // R10
      // hold the count at zero on the leaving edge so the first bit gets all 16 ticks
      if (tx_state_next == uart_pkg::TX_IDLE || tx_state_reg == uart_pkg::TX_IDLE) tx_tk_reg <= 4'h0;
      else if (tick) tx_tk_reg <= tx_tk_reg + 4'h1;
      if (tx_state_next != tx_state_reg) tx_bit_reg <= 4'h0;
      else if (tx_end && !(tx_state_reg == uart_pkg::TX_BRK && brk_ok)) tx_bit_reg <= tx_bit_reg + 4'h1;
    end
  end

  // transmit flags follow the same status-then-data sequence
  wire tx_quiet = (tx_state_reg == uart_pkg::TX_IDLE) && !hold_vld_reg && !brk_req && !wr_data;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txem_reg <= 1'b1;
      txdn_reg <= 1'b1;
    end else if (!tx_act) begin
      txem_reg <= 1'b1;
      txdn_reg <= 1'b1;
    end else begin
      if (tx_load) txem_reg <= 1'b1; // R23
      else if (wr_data && seen_reg[uart_pkg::S_TXEM]) txem_reg <= 1'b0;
      if (tx_quiet && txem_reg) txdn_reg <= 1'b1; // R21
      else if (wr_data && seen_reg[uart_pkg::S_TXDN] || hold_vld_reg || brk_req) txdn_reg <= 1'b0; // R22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign status = {parity_error_flag_reg, noise_reg, framing_error_flag_reg, ovr_reg,
                       rx_state_reg == uart_pkg::RX_IDLE, rxav_reg, txdn_reg, txem_reg}; // R17
  wire [7:0] rd_mux = (reg_addr == uart_pkg::A_DATA) ? fifo_mem[rd_ptr_reg][7:0] :
                      (reg_addr == uart_pkg::A_STAT) ? status :
                      (reg_addr == uart_pkg::A_CTL1) ? {ctl1_reg[7:1], 1'b0} :
                      (reg_addr == uart_pkg::A_CTL2) ? ctl2_reg :
                      (reg_addr == uart_pkg::A_BAUD) ? baud_reg : 8'h00;
  wire line = (tx_state_reg == uart_pkg::TX_START || tx_state_reg == uart_pkg::TX_BRK) ? 1'b0 :
              (tx_state_reg == uart_pkg::TX_DATA) ? tx_sh_reg[0] :
              (tx_state_reg == uart_pkg::TX_PAR) ? tx_par_reg : 1'b1; // R27
  wire c2_ie = ctl2_reg[uart_pkg::C2_RIE];
  wire irq_next = c2_ie && ((rxav_reg && (!ctl2_reg[uart_pkg::C2_ADR] || adr_hit_reg)) || ovr_reg)
                || ctl2_reg[uart_pkg::C2_TIIE] && txdn_reg || ctl2_reg[uart_pkg::C2_TEIE] && txem_reg; // R7

  // pins and read data all leave from flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata     <= 8'h00;
      tx_pin        <= 1'b1;
      tx_pin_oe_n   <= 1'b1;
      tx_pullup_off <= 1'b0;
      rx_pullup_off <= 1'b0;
      irq           <= 1'b0;
    end else begin
      reg_rdata     <= reg_rd ? rd_mux : 8'h00;
      tx_pin        <= tx_act ? line : 1'b1;
      tx_pin_oe_n   <= !tx_act; // R8 R9
      tx_pullup_off <= tx_act; // R8
      rx_pullup_off <= rx_act;
      irq           <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_brk_exit;
    (tx_state_reg == uart_pkg::TX_BRK) ##1 (tx_state_reg == uart_pkg::TX_IDLE);
  endsequence
  property p_brk_len;
    s_brk_exit |-> $past(tx_bit_reg, 2) >= uart_pkg::BRK_BITS || !$past(tx_act, 1);
  endproperty
  a_brk_len: assert property (p_brk_len) else $error("break too short"); // R26
  property p_float;
    !tx_act |=> tx_pin_oe_n && !tx_pullup_off;
  endproperty
  a_float: assert property (p_float) else $error("tx pin not released"); // R9
  property p_start_low;
    tx_act && tx_state_reg == uart_pkg::TX_START |=> !tx_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // R27
  property p_ovr_block;
    ovr_reg |=> fifo_cnt_reg <= $past(fifo_cnt_reg);
  endproperty
  a_ovr_block: assert property (p_ovr_block) else $error("push during overrun"); // R16
  property p_noise_with_push;
    $rose(noise_reg) |-> $past(push) && rxav_reg;
  endproperty
  a_noise_with_push: assert property (p_noise_with_push) else $error("noise without char"); // R14
  property p_fifo_depth;
    fifo_cnt_reg <= 2'h2;
  endproperty
  a_fifo_depth: assert property (p_fifo_depth) else $error("buffer over depth"); // R5
  property p_parity_error_flag_en;
    $rose(parity_error_flag_reg) |-> par_en;
  endproperty
  a_parity_error_flag_en: assert property (p_parity_error_flag_en) else $error("parity flag with parity off"); // R13
  property p_rxav_hold;
    rxav_reg && cnt_after != 2'h0 && g_on |=> rxav_reg;
  endproperty
  a_rxav_hold: assert property (p_rxav_hold) else $error("rx available lost"); // R20
  property p_idle_line;
    tx_act && txdn_reg ##1 tx_act && txdn_reg |-> tx_pin;
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("idle line low"); // R21
endmodule : async_serial_uart_core

// ### uart_pkg.sv
// constants shared by the serial core and its testbench
// assumes one system clock; register indices are word selects on reg_addr
package uart_pkg;
  // register selects on the processor data-memory port
  localparam logic [2:0] A_DATA = 3'h0;
  localparam logic [2:0] A_STAT = 3'h1;
  localparam logic [2:0] A_CTL1 = 3'h2;
  localparam logic [2:0] A_CTL2 = 3'h3;
  localparam logic [2:0] A_BAUD = 3'h4;
  // status bit positions
  localparam int S_PARITY_ERROR_FLAG  = 7;
  localparam int S_NOISE = 6;
  localparam int S_FRAMING_ERROR_FLAG  = 5;
  localparam int S_OVR   = 4;
  localparam int S_RXQ   = 3;
  localparam int S_RXAV  = 2;
  localparam int S_TXDN  = 1;
  localparam int S_TXEM  = 0;
  // control 1 bit positions
  localparam int C1_ON   = 7;
  localparam int C1_NINE = 6;
  localparam int C1_PEN  = 5;
  localparam int C1_ODD  = 4;
  localparam int C1_STP2 = 3;
  localparam int C1_BRK  = 2;
  localparam int C1_RX8  = 1;
  localparam int C1_TX8  = 0;
  // control 2 bit positions
  localparam int C2_TXON = 7;
  localparam int C2_RXON = 6;
  localparam int C2_ADR  = 4;
  localparam int C2_RIE  = 2;
  localparam int C2_TIIE = 1;
  localparam int C2_TEIE = 0;
  // reset values
  localparam logic [7:0] CTL_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // timing: ticks per bit, majority sample points, break length in bits
  localparam logic [3:0] OVS_LAST  = 4'hF;
  localparam logic [3:0] SMP_FIRST = 4'h7;
  localparam logic [3:0] SMP_LAST  = 4'h9;
  localparam logic [3:0] START_MID = 4'h8;
  localparam logic [3:0] BRK_BITS  = 4'hD;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6
  } rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_PAR = 3'h2, TX_STOP = 3'h6,
    TX_BRK = 3'h4
  } tx_state_t;
endpackage : uart_pkg

// ### baud_tick_gen.sv
// oversampling tick source for both shift directions
// assumes divisor is stable or that a clear follows a change
`timescale 1ns/1ps
module baud_tick_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             clear,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  wire              wrap = (cnt_reg == '0);

  // down counter reloads with the divisor, so the tick period is divisor+1
  assign cnt_next = (clear || wrap) ? divisor : cnt_reg - 1'b1;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= wrap && !clear;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_tick_gap;
    tick |=> !tick || $past(divisor) == '0;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("baud tick too dense"); // R4
endmodule : baud_tick_gen

// ### serial_peer.sv
// remote serial device model: captures frames from the core, sends frames to it
// assumes 8 data bits, no parity, one stop bit; bit time given in ns
`timescale 1ns/1ps
module serial_peer #(
  parameter int BIT_NS = 3200
) (
  input  wire logic       tx_line,
  output logic            rx_line,
  output logic [7:0]      got
);
  // line rests high between frames
  initial begin
    rx_line = 1'b1;
    got     = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // capture at mid-bit so small phase offsets do not matter
  always @(negedge tx_line) begin
    #(BIT_NS/2);
    if (tx_line == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        #(BIT_NS);
        got[i] = tx_line;
      end
      #(BIT_NS);
    end
  end
  // one frame: low start, data lsb first, one high stop
  task automatic send(input logic [7:0] b);
    rx_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      rx_line = b[i];
      #(BIT_NS);
    end
    rx_line = 1'b1;
    #(BIT_NS);
  endtask : send
endmodule : serial_peer

// ### async_serial_uart_core_tb.sv
// self-checking bench for the serial core through its register port
// assumes divisor 1 gives 32 clocks per bit; peer model drives the rx line
`timescale 1ns/1ps
module async_serial_uart_core_tb;
  logic       mclk, resetn, reg_rd, reg_wr;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, v;
  wire  [7:0] reg_rdata, got;
  wire        rx_pin, tx_pin, tx_pin_oe_n, tx_pullup_off, rx_pullup_off, irq;
  int         num_errors, samples_checked;
  async_serial_uart_core DUT (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .tx_pin_oe_n(tx_pin_oe_n), .tx_pullup_off(tx_pullup_off), .rx_pullup_off(rx_pullup_off), .irq(irq));
  serial_peer #(.BIT_NS(3200)) peer (.tx_line(tx_pin), .rx_line(rx_pin), .got(got));
  //////////////////////////////////////////////////////////////////////////////
  // clock at 10 MHz
  always #50 mclk = ~mclk;
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check
  // strobes rise 1 ns after an edge and drop 1 ns after the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge mclk);
    #1;
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask : rd
  task automatic report_and_stop;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // watchdog: the tests need about 200 us
  initial begin
    #1000000;
    num_errors++;
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {mclk, resetn, reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    rd(uart_pkg::A_STAT, v); check(v, 8'h0B);
    rd(3'h5, v); check(v, 8'h00);
    wr(uart_pkg::A_BAUD, 8'h01);
    wr(uart_pkg::A_CTL1, 8'h80);
    wr(uart_pkg::A_CTL2, 8'hC4);
    repeat (2) @(posedge mclk);
    #1;
    check({tx_pin_oe_n, tx_pullup_off, rx_pullup_off, tx_pin}, 8'h07);
    rd(uart_pkg::A_STAT, v); check(v, 8'h0B);
    wr(uart_pkg::A_DATA, 8'hA5);
    repeat (11 * 32) @(posedge mclk);
    #1;
    check(got, 8'hA5);
    rd(uart_pkg::A_STAT, v); check(v, 8'h0B);
    // three characters into a two-deep buffer
    peer.send(8'h11);
    peer.send(8'h22);
    peer.send(8'h33);
    repeat (32) @(posedge mclk);
    #1;
    check({7'h00, irq}, 8'h01);
    rd(uart_pkg::A_STAT, v); check(v, 8'h1F);
    rd(uart_pkg::A_DATA, v); check(v, 8'h11);
    rd(uart_pkg::A_STAT, v); check(v, 8'h0F);
    rd(uart_pkg::A_DATA, v); check(v, 8'h22);
    rd(uart_pkg::A_STAT, v); check(v, 8'h0B);
    check({7'h00, irq}, 8'h00);
    // break: line low past thirteen bits while requested, then high again
    wr(uart_pkg::A_CTL1, 8'h84);
    repeat (14 * 32) @(posedge mclk);
    #1;
    check({7'h00, tx_pin}, 8'h00);
    rd(uart_pkg::A_STAT, v); check(v, 8'h09);
    wr(uart_pkg::A_CTL1, 8'h80);
    repeat (2 * 32) @(posedge mclk);
    #1;
    check({7'h00, tx_pin}, 8'h01);
    check(got, 8'h00);
    rd(uart_pkg::A_STAT, v); check(v, 8'h0B);
    wr(uart_pkg::A_CTL1, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    check({tx_pin_oe_n, tx_pullup_off, rx_pullup_off}, 8'h04);
    report_and_stop();
  end
endmodule : async_serial_uart_core_tb
